/* rtl/cbx_pkg.sv */
// Package: constants, opcodes and register map of the bit-op and load/store executor
package cbx_pkg;
    // Avalon byte addresses
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ARG = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_PC = 8'h0C;
    localparam logic [7:0] REG_FLAGS = 8'h10;
    localparam logic [7:0] REG_PAGE = 8'h14;
    localparam int GPR_SEL_BIT = 7;
    localparam int GPR_IDX_HI = 6;
    localparam int GPR_IDX_LO = 2;
    // Flag register bit positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;
    localparam int FLG_I = 7;
    // Pointer pairs, low register index
    localparam logic [4:0] PTR_X = 5'h1A;
    localparam logic [4:0] PTR_Y = 5'h1C;
    localparam logic [4:0] PTR_Z = 5'h1E;
    localparam logic [4:0] REG_R0 = 5'h00;
    // Instruction word fields
    localparam int F_OP_HI = 15;
    localparam int F_OP_LO = 11;
    localparam int F_RD_HI = 10;
    localparam int F_RD_LO = 6;
    localparam int F_Q_HI = 5;
    localparam int F_OFF_HI = 6;
    localparam int F_BIT_HI = 2;
    localparam int F_SEL_HI = 1;
    localparam int F_MODE_HI = 3;
    localparam int F_MODE_LO = 2;
    localparam int F_POST = 0;
    localparam int F_R0 = 1;
    localparam logic [1:0] MODE_PLAIN = 2'h0;
    localparam logic [1:0] MODE_POST = 2'h1;
    localparam logic [1:0] MODE_PRE = 2'h2;
    localparam logic [1:0] SPC_DATA = 2'h0;
    localparam logic [1:0] SPC_IO = 2'h1;
    localparam logic [1:0] SPC_PROG = 2'h2;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_BR_VC = 5'h01, OP_BR_IE = 5'h02, OP_BR_ID = 5'h03,
        OP_IO_SET = 5'h04, OP_IO_CLR = 5'h05, OP_LSL = 5'h06, OP_LSR = 5'h07,
        OP_ROL = 5'h08, OP_ROR = 5'h09, OP_ASR = 5'h0A, OP_FSET = 5'h0B,
        OP_FCLR = 5'h0C, OP_BST = 5'h0D, OP_BLD = 5'h0E, OP_SEI = 5'h0F,
        OP_CLI = 5'h10, OP_LD_IND = 5'h11, OP_LDD_Y = 5'h12, OP_LDD_Z = 5'h13,
        OP_LDS = 5'h14, OP_ST_IND = 5'h15, OP_STD_Y = 5'h16, OP_STD_Z = 5'h17,
        OP_STS = 5'h18, OP_LPM = 5'h19, OP_PROGRAM_MEMORY_READ_EXTENDED = 5'h1A
    } cbx_op_t;
    typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} cbx_state_t;
endpackage

/* rtl/cbx_exec.sv */
// Executor for branches, bit, shift, flag and load/store operations behind Avalon-MM
// Notes on behaviour
// RQ1: overflow clear branch to PC+k+1, 1/2 cycles
// RQ2: interrupt flag branches both polarities, 1/2 cycles
// RQ3: I/O bit set/clear, two cycles, flags kept
// RQ4: left shift zero fill, ZCNV, one cycle
// RQ5: right shift zero fill, ZCNV, one cycle
// RQ6: left rotate through carry, ZCNV, one cycle
// RQ7: right rotate through carry, ZCNV, one cycle
// RQ8: arithmetic right shift keeps bit 7
// RQ9: set or clear any one flag
// RQ10: global interrupt on/off, one cycle only
// RQ11: register bit into T flag
// RQ12: T flag into register bit
// RQ13: indirect load, optional post-increment, two cycles
// RQ14: pre-decrement pointer then load, two cycles
// RQ15: displacement load, pointer unchanged, two cycles
// RQ16: direct load from instruction address, two cycles
// RQ17: indirect store, optional post-increment, two cycles
// RQ18: pre-decrement pointer then store, two cycles
// RQ19: displacement store, pointer unchanged, two cycles
// RQ20: direct store to instruction address, two cycles
// RQ21: program memory read by Z, three cycles
// RQ22: extended read with page:Z, whole increment
// RQ23: pointers are 16-bit register pairs
// RQ24: branch offset sign-extended before adding
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module cbx_exec
    import cbx_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] mem_space_o,
    output logic [23:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    output logic [2:0] mem_bit_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic mem_bitwr_o,
    input wire logic [7:0] mem_rdata_i
);
    typedef struct packed {
        logic stall;
        logic [31:0] rdata;
        cbx_state_t state;
        logic [1:0] cnt;
        logic [1:0] len;
        logic [15:0] instr;
        logic [15:0] arg;
        logic [15:0] pc;
        logic [7:0] flags;
        logic [7:0] page;
        logic [31:0][7:0] regs;
        logic [1:0] space;
        logic [23:0] addr;
        logic [7:0] wdata;
        logic [2:0] bitno;
        logic rd;
        logic wr;
        logic bitwr;
    } cbx_regs_t;

    cbx_regs_t s_ff;
    cbx_regs_t nxt_s;
    logic launch;
    logic fin;
    logic [15:0] iw;
    cbx_op_t op;
    logic [4:0] rd;
    logic [4:0] pbase;
    logic [1:0] mode;
    logic [15:0] ptr;
    logic [15:0] ptr_step;
    logic [15:0] eaddr;
    logic taken;
    logic [8:0] sh;
    logic [4:0] ldst;
    logic [23:0] paddr;
    logic [31:0] rmux;
    logic [31:0] wnew;

    function automatic logic [15:0] sext_off(input logic [6:0] k);
        return {{9{k[6]}}, k};
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Returns {carry, result}
    function automatic logic [8:0] shift_op(input cbx_op_t o, input logic [7:0] v,
                                            input logic c);
        unique case (o)
            OP_LSL: return {v[7], v[6:0], 1'b0}; // RQ4
            OP_LSR: return {v[0], 1'b0, v[7:1]}; // RQ5
            OP_ROL: return {v[7], v[6:0], c}; // RQ6
            OP_ROR: return {v[0], c, v[7:1]}; // RQ7
            default: return {v[0], v[7], v[7:1]}; // RQ8
        endcase
    endfunction

    always_comb begin
        nxt_s = s_ff;
        nxt_s.rd = 1'b0;
        nxt_s.wr = 1'b0;
        nxt_s.bitwr = 1'b0;
        launch = !s_ff.stall && avs_write_i && avs_address_i == REG_CMD;
        fin = s_ff.state == ST_RUN && s_ff.cnt == s_ff.len;
        // Decode the incoming word at launch, the latched one while running
        iw = launch ? avs_writedata_i[15:0] : s_ff.instr;
        op = cbx_op_t'(iw[F_OP_HI:F_OP_LO]);
        rd = iw[F_RD_HI:F_RD_LO];
        mode = iw[F_MODE_HI:F_MODE_LO];
        unique case (op)
            OP_LD_IND, OP_ST_IND: begin
                pbase = iw[F_SEL_HI:0] == 2'h0 ? PTR_X : (iw[F_SEL_HI:0] == 2'h1 ? PTR_Y : PTR_Z);
            end
            OP_LDD_Y, OP_STD_Y: pbase = PTR_Y;
            default: pbase = PTR_Z;
        endcase
        ptr = {s_ff.regs[pbase + 5'h01], s_ff.regs[pbase]}; // RQ23
        ptr_step = mode == MODE_PRE ? ptr - 16'h0001 : ptr + 16'h0001; // RQ23
        unique case (op)
            OP_LDD_Y, OP_LDD_Z, OP_STD_Y, OP_STD_Z: eaddr = ptr + {10'h000, iw[F_Q_HI:0]}; // RQ15 RQ19
            OP_LDS, OP_STS: eaddr = s_ff.arg; // RQ16 RQ20
            default: eaddr = mode == MODE_PRE ? ptr_step : ptr; // RQ14 RQ18
        endcase
        paddr = {op == OP_PROGRAM_MEMORY_READ_EXTENDED ? s_ff.page : 8'h00, ptr}; // RQ22
        ldst = iw[F_R0] ? REG_R0 : rd;
        sh = shift_op(op, s_ff.regs[rd], s_ff.flags[FLG_C]);
        unique case (op)
            OP_BR_VC: taken = !s_ff.flags[FLG_V]; // RQ1
            OP_BR_IE: taken = s_ff.flags[FLG_I]; // RQ2
            OP_BR_ID: taken = !s_ff.flags[FLG_I]; // RQ2
            default: taken = 1'b0;
        endcase

        // One mux serves the read answer and the byte-enable merge of a write
        if (avs_address_i[GPR_SEL_BIT]) begin
            rmux = {24'h000000, s_ff.regs[avs_address_i[GPR_IDX_HI:GPR_IDX_LO]]};
        end else begin
            unique case (avs_address_i)
                REG_CMD: rmux = {16'h0000, s_ff.instr};
                REG_ARG: rmux = {16'h0000, s_ff.arg};
                REG_PC: rmux = {16'h0000, s_ff.pc};
                REG_FLAGS: rmux = {24'h000000, s_ff.flags};
                REG_PAGE: rmux = {24'h000000, s_ff.page};
                default: rmux = 32'h00000000;
            endcase
        end
        wnew = be_merge(rmux, avs_writedata_i, avs_byteenable_i);
        // Avalon slave: stall through any busy cycles, then one more stall cycle, then the answer edge
        if (!s_ff.stall) begin
            nxt_s.stall = 1'b1;
        end else if ((avs_read_i || avs_write_i) && s_ff.state == ST_IDLE) begin
            nxt_s.stall = 1'b0;
            nxt_s.rdata = rmux;
        end
        if (!s_ff.stall && avs_write_i) begin
            if (avs_address_i[GPR_SEL_BIT]) begin
                nxt_s.regs[avs_address_i[GPR_IDX_HI:GPR_IDX_LO]] = wnew[7:0];
            end else begin
                unique case (avs_address_i)
                    REG_CMD: nxt_s.instr = wnew[15:0];
                    REG_ARG: nxt_s.arg = wnew[15:0];
                    REG_PC: nxt_s.pc = wnew[15:0];
                    REG_FLAGS: nxt_s.flags = wnew[7:0];
                    REG_PAGE: nxt_s.page = wnew[7:0];
                    default: nxt_s.stall = 1'b1;
                endcase
            end
        end

        // Launch: fix the length and issue the memory strobe at once
        if (launch) begin
            nxt_s.instr = iw;
            nxt_s.state = ST_RUN;
            nxt_s.cnt = CYC_ONE;
            nxt_s.space = SPC_DATA;
            nxt_s.addr = {8'h00, eaddr};
            nxt_s.wdata = s_ff.regs[rd];
            nxt_s.bitno = iw[F_BIT_HI:0];
            unique case (op)
                OP_BR_VC, OP_BR_IE, OP_BR_ID: nxt_s.len = taken ? CYC_TWO : CYC_ONE; // RQ1 RQ2
                OP_IO_SET, OP_IO_CLR: begin
                    // Bit write goes out as one strobe; the I/O side merges it
                    nxt_s.len = CYC_TWO; // RQ3
                    nxt_s.space = SPC_IO;
                    nxt_s.addr = {19'h00000, rd};
                    nxt_s.wdata = {7'h00, op == OP_IO_SET};
                    nxt_s.bitwr = 1'b1;
                end
                OP_LD_IND, OP_LDD_Y, OP_LDD_Z, OP_LDS: begin
                    nxt_s.len = CYC_TWO; // RQ13 RQ14 RQ15 RQ16
                    nxt_s.rd = 1'b1;
                end
                OP_ST_IND, OP_STD_Y, OP_STD_Z, OP_STS: begin
                    nxt_s.len = CYC_TWO; // RQ17 RQ18 RQ19 RQ20
                    nxt_s.wr = 1'b1;
                end
                OP_LPM, OP_PROGRAM_MEMORY_READ_EXTENDED: begin
                    nxt_s.len = CYC_THREE; // RQ21 RQ22
                    nxt_s.space = SPC_PROG;
                    nxt_s.addr = paddr;
                    nxt_s.rd = 1'b1;
                end
                default: nxt_s.len = CYC_ONE;
            endcase
        end else if (s_ff.state == ST_RUN && !fin) begin
            nxt_s.cnt = s_ff.cnt + CYC_ONE;
        end

        // Register, flag and PC effects land on the last edge of the instruction; memory and I/O writes land one edge after launch
        if (fin) begin
            nxt_s.state = ST_IDLE;
            nxt_s.pc = s_ff.pc + 16'h0001;
            unique case (op)
                OP_BR_VC, OP_BR_IE, OP_BR_ID: begin
                    if (taken) begin
                        nxt_s.pc = s_ff.pc + sext_off(iw[F_OFF_HI:0]) + 16'h0001; // RQ1 RQ2 RQ24
                    end
                end
                OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR: begin
                    nxt_s.regs[rd] = sh[7:0]; // RQ4 RQ5 RQ6 RQ7 RQ8
                    nxt_s.flags[FLG_C] = sh[8];
                    nxt_s.flags[FLG_Z] = sh[7:0] == 8'h00;
                    nxt_s.flags[FLG_N] = sh[7];
                    nxt_s.flags[FLG_V] = sh[7] ^ sh[8];
                end
                OP_FSET: nxt_s.flags[iw[F_BIT_HI:0]] = 1'b1; // RQ9
                OP_FCLR: nxt_s.flags[iw[F_BIT_HI:0]] = 1'b0; // RQ9
                OP_SEI: nxt_s.flags[FLG_I] = 1'b1; // RQ10
                OP_CLI: nxt_s.flags[FLG_I] = 1'b0; // RQ10
                OP_BST: nxt_s.flags[FLG_T] = s_ff.regs[rd][iw[F_BIT_HI:0]]; // RQ11
                OP_BLD: nxt_s.regs[rd][iw[F_BIT_HI:0]] = s_ff.flags[FLG_T]; // RQ12
                OP_LD_IND, OP_ST_IND: begin
                    if (op == OP_LD_IND) begin
                        nxt_s.regs[rd] = mem_rdata_i; // RQ13
                    end
                    // Pointer write-back last, so it wins over a load into the pointer
                    if (mode == MODE_POST || mode == MODE_PRE) begin
                        nxt_s.regs[pbase] = ptr_step[7:0]; // RQ13 RQ14 RQ17 RQ18
                        nxt_s.regs[pbase + 5'h01] = ptr_step[15:8];
                    end
                end
                OP_LDD_Y, OP_LDD_Z, OP_LDS: nxt_s.regs[rd] = mem_rdata_i; // RQ15 RQ16
                OP_LPM, OP_PROGRAM_MEMORY_READ_EXTENDED: begin
                    nxt_s.regs[ldst] = mem_rdata_i; // RQ21
                    if (iw[F_POST]) begin
                        {nxt_s.page, nxt_s.regs[PTR_Z + 5'h01], nxt_s.regs[PTR_Z]} =
                            paddr + 24'h000001; // RQ22
                        if (op == OP_LPM) begin
                            nxt_s.page = s_ff.page;
                        end
                    end
                end
                default: nxt_s.pc = s_ff.pc + 16'h0001;
            endcase
        end
        if (!s_ff.stall && avs_read_i && avs_address_i == REG_STAT) begin
            nxt_s.rdata = 32'h00000000;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_ff <= '0;
            s_ff.stall <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign avs_readdata_o = s_ff.rdata;
    assign avs_waitrequest_o = s_ff.stall;
    assign mem_space_o = s_ff.space;
    assign mem_addr_o = s_ff.addr;
    assign mem_wdata_o = s_ff.wdata;
    assign mem_bit_o = s_ff.bitno;
    assign mem_rd_o = s_ff.rd;
    assign mem_wr_o = s_ff.wr;
    assign mem_bitwr_o = s_ff.bitwr;

    logic busy;
    cbx_op_t op_r;
    assign busy = s_ff.state == ST_RUN;
    assign op_r = cbx_op_t'(s_ff.instr[F_OP_HI:F_OP_LO]);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_wait_busy: assert property (busy |-> avs_waitrequest_o)
        else $error("waitrequest low while executing");
    a_strobe_pulse: assert property (mem_rd_o || mem_wr_o |=> !mem_rd_o && !mem_wr_o)
        else $error("memory strobe longer than one cycle");
    a_branch_vc_taken: assert property ($rose(busy) && op_r == OP_BR_VC && !s_ff.flags[FLG_V]
        |-> busy ##1 busy ##1 !busy && s_ff.pc == $past(s_ff.pc, 2)
        + sext_off(s_ff.instr[F_OFF_HI:0]) + 16'h0001) // RQ1
        else $error("overflow-clear branch target or length wrong");
    a_branch_ie_skip: assert property ($rose(busy) && op_r == OP_BR_IE && !s_ff.flags[FLG_I]
        |=> !busy && s_ff.pc == $past(s_ff.pc) + 16'h0001) // RQ2
        else $error("untaken interrupt branch wrong");
    a_io_set_bit: assert property ($rose(busy) && op_r == OP_IO_SET
        |-> mem_bitwr_o && mem_wdata_o[0] && mem_space_o == SPC_IO ##1 busy && !mem_bitwr_o
        ##1 !busy) // RQ3
        else $error("I/O bit set strobe or length wrong");
    a_lsl_result: assert property ($rose(busy) && op_r == OP_LSL
        |=> s_ff.regs[rd][0] == 1'b0 && s_ff.flags[FLG_C] == $past(s_ff.regs[rd][7])) // RQ4
        else $error("left shift result or carry wrong");
    a_sei_only: assert property ($rose(busy) && op_r == OP_SEI
        |=> s_ff.flags == ($past(s_ff.flags) | (8'h01 << FLG_I))) // RQ10
        else $error("interrupt enable changed other flags");
    a_load_flags: assert property ($rose(busy) && op_r == OP_LD_IND
        |-> ##2 !busy && s_ff.flags == $past(s_ff.flags, 2)) // RQ13
        else $error("indirect load length or flags wrong");
    a_predec_addr: assert property ($rose(busy) && op_r == OP_LD_IND && mode == MODE_PRE
        |-> mem_rd_o && mem_addr_o[15:0] == ptr - 16'h0001) // RQ14
        else $error("pre-decrement address wrong");
    a_lpm_len: assert property ($rose(busy) && op_r == OP_LPM
        |-> mem_rd_o && mem_space_o == SPC_PROG ##1 busy [*2] ##1 !busy) // RQ21
        else $error("program read length wrong");
endmodule // cbx_exec

/* testbench/cbx_mem_model.sv */
// Behavioural data, I/O and program memory on the far side of the executor
`timescale 1ns/1ps
module cbx_mem_model
    import cbx_pkg::*;
(
    input wire logic clk_i,
    input wire logic [1:0] space_i,
    input wire logic [23:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [2:0] bit_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic bitwr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] dmem [0:65535];
    logic [7:0] io [0:31];
    logic [1:0] pend = 2'h0;
    logic [1:0] pspace = 2'h0;
    logic [23:0] paddr = 24'h0;
    logic [7:0] junk = 8'h55;
    function automatic logic [7:0] pval(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
    endfunction
    initial begin
        for (int i = 0; i < 65536; i++) dmem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3C;
        for (int i = 0; i < 32; i++) io[i] = 8'h00;
    end
    // Data is valid only in the cycle the core samples it; junk otherwise so stale bytes never pass
    always @(posedge clk_i) begin
        junk <= ~junk;
        if (rd_i) begin
            pend <= (space_i == SPC_PROG) ? 2'h2 : 2'h1;
            paddr <= addr_i;
            pspace <= space_i;
        end else if (pend != 2'h0) begin
            pend <= pend - 2'h1;
        end
        if (wr_i && space_i == SPC_IO) begin
            io[addr_i[4:0]] <= wdata_i;
        end else if (wr_i) begin
            dmem[addr_i[15:0]] <= wdata_i;
        end
        if (bitwr_i) begin
            io[addr_i[4:0]][bit_i] <= wdata_i[0];
        end
    end
    assign rdata_o = (pend != 2'h1) ? junk : (pspace == SPC_PROG) ? pval(paddr) :
        (pspace == SPC_IO) ? io[paddr[4:0]] : dmem[paddr[15:0]];
endmodule // cbx_mem_model

/* testbench/cbx_exec_tb_top.sv */
// Self-checking bench for the bit-op and load/store executor
`timescale 1ns/1ps
module cbx_exec_tb_top
    import cbx_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [1:0] mem_space_o;
    logic [23:0] mem_addr_o;
    logic [7:0] mem_wdata_o;
    logic [2:0] mem_bit_o;
    logic mem_rd_o;
    logic mem_wr_o;
    logic mem_bitwr_o;
    logic [7:0] mem_rdata_i;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    cbx_exec dut (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .mem_space_o(mem_space_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_bit_o(mem_bit_o),
        .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_bitwr_o(mem_bitwr_o),
        .mem_rdata_i(mem_rdata_i));
    cbx_mem_model mem (.clk_i(clk_i), .space_i(mem_space_o), .addr_i(mem_addr_o),
        .wdata_i(mem_wdata_o), .bit_i(mem_bit_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
        .bitwr_i(mem_bitwr_o), .rdata_o(mem_rdata_i));
    always #5 clk_i = ~clk_i;
    task automatic end_sim;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // A hang anywhere ends here as a mismatch
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim;
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Held until the rising edge that samples waitrequest low; n counts edges to it
    task automatic av(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] q, output int n);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_write_i <= w;
        avs_read_i <= !w;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        int k;
        av(1'b1, a, d, x, k);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] x);
        int k;
        av(1'b0, a, 32'h0, x, k);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        rd(a, x);
        chk(nm, x, e);
    endtask
    function automatic logic [7:0] ga(input int r);
        return 8'h80 + 8'(r * 4);
    endfunction
    function automatic logic [15:0] iw(input cbx_op_t op, input logic [4:0] r,
            input logic [5:0] lo);
        return {op, r, lo};
    endfunction
    // A status read after the launch waits out the busy cycles plus one answer cycle
    task automatic run(input logic [15:0] w, input int len);
        logic [31:0] x;
        int k;
        av(1'b1, REG_CMD, {16'h0, w}, x, k);
        av(1'b0, REG_STAT, 32'h0, x, k);
        chk("cycles", k, len + 1);
    endtask
    task automatic setp(input logic [4:0] b, input logic [15:0] p);
        wr(ga(int'(b)), {24'h0, p[7:0]});
        wr(ga(int'(b) + 1), {24'h0, p[15:8]});
    endtask
    task automatic pchk(input logic [4:0] b, input logic [15:0] p);
        rdchk("ptr_lo", ga(int'(b)), {24'h0, p[7:0]});
        rdchk("ptr_hi", ga(int'(b) + 1), {24'h0, p[15:8]});
    endtask
    task automatic t_shift;
        cbx_op_t ops [5] = '{OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR};
        logic [7:0] v, r;
        logic c, ci;
        for (int i = 0; i < 10; i++) begin
            v = (i < 5) ? 8'h81 : 8'h00;
            ci = (i >= 5);
            case (ops[i % 5])
                OP_LSL: {c, r} = {v, 1'b0};
                OP_LSR: {r, c} = {1'b0, v};
                OP_ROL: {c, r} = {v, ci};
                OP_ROR: {r, c} = {ci, v};
                default: {r, c} = {v[7], v};
            endcase
            wr(ga(16), {24'h0, v});
            wr(REG_FLAGS, {24'h0, 7'h18, ci});
            run(iw(ops[i % 5], 5'd16, 6'h00), 1);
            rdchk("shift_res", ga(16), {24'h0, r});
            rdchk("shift_flg", REG_FLAGS, {28'h3, r[7] ^ c, r[7], r == 8'h00, c});
        end
    endtask
    task automatic t_flag;
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            b = 8'h01 << i;
            wr(REG_FLAGS, 32'h5A);
            run(iw(OP_FSET, 5'd0, 6'(i)), 1);
            rdchk("flag_set", REG_FLAGS, {24'h0, 8'h5A | b});
            run(iw(OP_FCLR, 5'd0, 6'(i)), 1);
            rdchk("flag_clr", REG_FLAGS, {24'h0, 8'h5A & ~b});
        end
        run(iw(OP_SEI, 5'd0, 6'h00), 1);
        rdchk("irq_on", REG_FLAGS, 32'hDA);
        run(iw(OP_CLI, 5'd0, 6'h00), 1);
        rdchk("irq_off", REG_FLAGS, 32'h5A);
    endtask
    task automatic t_tbit;
        wr(ga(5), 32'h20);
        wr(ga(6), 32'hA4);
        wr(REG_FLAGS, 32'h00);
        run(iw(OP_BST, 5'd5, 6'h05), 1);
        rdchk("t_set", REG_FLAGS, 32'h40);
        run(iw(OP_BLD, 5'd6, 6'h00), 1);
        rdchk("bld_one", ga(6), 32'hA5);
        rdchk("bld_flg", REG_FLAGS, 32'h40);
        run(iw(OP_BST, 5'd5, 6'h04), 1);
        rdchk("t_clr", REG_FLAGS, 32'h00);
        run(iw(OP_BLD, 5'd6, 6'h02), 1);
        rdchk("bld_zero", ga(6), 32'hA1);
    endtask
    task automatic t_io;
        wr(REG_FLAGS, 32'h55);
        run(iw(OP_IO_SET, 5'h07, 6'h03), 2);
        chk("io_set", {24'h0, mem.io[7]}, 32'h08);
        run(iw(OP_IO_SET, 5'h1F, 6'h07), 2);
        chk("io_set_hi", {24'h0, mem.io[31]}, 32'h80);
        run(iw(OP_IO_CLR, 5'h07, 6'h03), 2);
        chk("io_clr", {24'h0, mem.io[7]}, 32'h00);
        rdchk("io_flg", REG_FLAGS, 32'h55);
    endtask
    task automatic t_ldst;
        logic [15:0] a, np;
        logic [4:0] b;
        logic [1:0] m, s;
        logic [7:0] e;
        wr(REG_FLAGS, 32'h7E);
        for (int i = 0; i < 18; i++) begin
            s = 2'((i % 9) / 3);
            b = PTR_X + {2'b00, s, 1'b0};
            m = 2'(i % 3);
            a = (m == MODE_PRE) ? 16'h20FE : 16'h20FF;
            np = (m == MODE_POST) ? 16'h2100 : a;
            setp(b, 16'h20FF);
            e = 8'hC0 + 8'(i);
            wr(ga(3), {24'h0, e});
            if (i < 9) begin
                e = mem.dmem[a];
                run(iw(OP_LD_IND, 5'd3, {2'b00, m, s}), 2);
                rdchk("ld", ga(3), {24'h0, e});
            end else begin
                run(iw(OP_ST_IND, 5'd3, {2'b00, m, s}), 2);
                chk("st", {24'h0, mem.dmem[a]}, {24'h0, e});
            end
            pchk(b, np);
        end
        setp(PTR_Y, 16'h10F0);
        setp(PTR_Z, 16'h30F0);
        run(iw(OP_LDD_Y, 5'd4, 6'h3F), 2);
        rdchk("ldd_y", ga(4), {24'h0, mem.dmem[16'h112F]});
        run(iw(OP_STD_Z, 5'd4, 6'h3F), 2);
        chk("std_z", {24'h0, mem.dmem[16'h312F]}, {24'h0, mem.dmem[16'h112F]});
        run(iw(OP_LDD_Z, 5'd5, 6'h00), 2);
        run(iw(OP_STD_Y, 5'd5, 6'h01), 2);
        chk("std_y", {24'h0, mem.dmem[16'h10F1]}, {24'h0, mem.dmem[16'h30F0]});
        pchk(PTR_Y, 16'h10F0);
        pchk(PTR_Z, 16'h30F0);
        wr(REG_ARG, 32'h3456);
        run(iw(OP_LDS, 5'd7, 6'h00), 2);
        rdchk("lds", ga(7), {24'h0, mem.dmem[16'h3456]});
        wr(REG_ARG, 32'h4567);
        run(iw(OP_STS, 5'd7, 6'h00), 2);
        chk("sts", {24'h0, mem.dmem[16'h4567]}, {24'h0, mem.dmem[16'h3456]});
        rdchk("ldst_flg", REG_FLAGS, 32'h7E);
    endtask
    task automatic t_prog;
        wr(REG_PAGE, 32'h03);
        setp(PTR_Z, 16'h01FF);
        run(iw(OP_LPM, 5'd9, 6'h02), 3);
        rdchk("lpm_r0", ga(0), {24'h0, mem.pval(24'h0001FF)});
        run(iw(OP_LPM, 5'd9, 6'h01), 3);
        rdchk("lpm_rd", ga(9), {24'h0, mem.pval(24'h0001FF)});
        pchk(PTR_Z, 16'h0200);
        setp(PTR_Z, 16'hFFFF);
        run(iw(OP_PROGRAM_MEMORY_READ_EXTENDED, 5'd9, 6'h01), 3);
        rdchk("program_memory_read_extended_rd", ga(9), {24'h0, mem.pval(24'h03FFFF)});
        pchk(PTR_Z, 16'h0000);
        rdchk("program_memory_read_extended_pg", REG_PAGE, 32'h04);
        run(iw(OP_PROGRAM_MEMORY_READ_EXTENDED, 5'd9, 6'h02), 3);
        rdchk("program_memory_read_extended_r0", ga(0), {24'h0, mem.pval(24'h040000)});
    endtask
    task automatic t_branch;
        cbx_op_t ops [6] = '{OP_BR_VC, OP_BR_VC, OP_BR_IE, OP_BR_IE, OP_BR_ID, OP_BR_ID};
        logic [7:0] fl [6] = '{8'h00, 8'h08, 8'h80, 8'h7F, 8'h7F, 8'h80};
        logic [6:0] k;
        logic [15:0] e;
        logic [31:0] pc;
        for (int i = 0; i < 6; i++) begin
            k = (i < 2) ? 7'h14 : 7'h7D;
            wr(REG_FLAGS, {24'h0, fl[i]});
            rd(REG_PC, pc);
            e = pc[15:0] + 16'h1 + ((i % 2 == 0) ? {{9{k[6]}}, k} : 16'h0);
            run({ops[i], 4'h0, k}, 2 - (i % 2));
            rd(REG_PC, pc);
            chk("pc", {16'h0, pc[15:0]}, {16'h0, e});
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        rdchk("flg_rst", REG_FLAGS, 32'h0);
        rdchk("unmapped", 8'h40, 32'h0);
        run(16'h0000, 1);
        t_shift;
        t_flag;
        t_tbit;
        t_io;
        t_ldst;
        t_prog;
        t_branch;
        end_sim;
    end
endmodule // cbx_exec_tb_top
